/* File: rtl/smsc_core.sv */
// byte serial port, master or slave, with receive fifo
// assumes pins arrive unsynchronised; control bits are driven by local logic
module smsc_core
  import smsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       spi_enable,
  input  wire logic       master_write,
  input  wire logic       master_wdata,
  output logic            master_select_bit,
  input  wire logic       bit_order_select,
  input  wire logic       clock_idle_polarity,
  input  wire logic       clock_sample_phase,
  input  wire logic       rate_select_high,
  input  wire logic       rate_select_low,
  input  wire logic       double_rate_bit,
  input  wire logic       transfer_irq_enable,
  input  wire logic       ss_dir_out,
  input  wire logic       user_mosi_dir,
  input  wire logic       user_sck_dir,
  input  wire logic       user_miso_dir,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       flag_clear,
  output logic            transfer_done_flag,
  output logic            rx_overrun_flag,
  output logic            transfer_irq,
  output logic [7:0]      rx_buf,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_n,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_n,
  input  wire logic       ss_n_in
);
  logic [3:0]          sync1_reg;
  logic [3:0]          sync2_reg;
  logic                sck_prev_reg;
  logic                master_reg;
  smsc_state_t         st_reg;
  logic [HALF_W-1:0]   div_reg;
  logic [HALF_W-1:0]   half;
  logic [3:0]          edge_reg;
  logic [7:0]          tx_sr_reg;
  logic [7:0]          rx_sr_reg;
  logic [7:0]          rx_next;
  logic [7:0]          rx_byte;
  logic                sck_reg;
  logic                flag_reg;
  logic                ovr_reg;
  logic                irq_reg;
  logic [7:0]          rx_buf_reg;
  logic                ss_s;
  logic                sck_s;
  logic                master_mode;
  logic                slave_mode;
  logic                slave_sel;
  logic                mode_fault;
  logic                m_tick;
  logic                ev;
  logic                sample;
  logic                done;
  logic                m_end;
  logic                accept;
  logic                in_bit;
  logic                fifo_rdy;
  logic                flag_next;

  // two-flop synchronisers: {miso, mosi, sck, select}
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      sync1_reg <= 4'h1;
      sync2_reg <= 4'h1;
    end
    else
    begin
      sync1_reg <= {miso_in, mosi_in, sck_in, ss_n_in};
      sync2_reg <= sync1_reg;
    end

  assign ss_s  = sync2_reg[0];
  assign sck_s = sync2_reg[1];

  always_ff @(posedge clk)
    if (sys_rst)
      sck_prev_reg <= 1'b0;
    else
      sck_prev_reg <= sck_s;

  assign master_mode = spi_enable & master_reg;
  assign slave_mode  = spi_enable & ~master_reg;
  assign slave_sel   = slave_mode & ~ss_s;
  assign mode_fault  = master_mode & ~ss_dir_out & ~ss_s;
  assign half        = rate_half(double_rate_bit, {rate_select_high, rate_select_low});
  assign m_tick      = (st_reg == ST_RUN) & (div_reg == half - 1'b1);
  // slave edges come from the sampled pin clock, so it must run at most clk/4
  assign ev          = master_mode ? m_tick & ~mode_fault
                                   : slave_sel & (sck_s != sck_prev_reg);
  assign sample      = ~edge_reg[0] ^ clock_sample_phase;
  assign in_bit      = master_mode ? sync2_reg[3] : sync2_reg[2];
  assign done        = ev & sample & (edge_reg[3:1] == LAST_BIT);
  assign m_end       = master_mode & ev & (edge_reg == LAST_EDGE);
  assign rx_next     = {rx_sr_reg[6:0], in_bit};
  assign rx_byte     = bit_order_select ? bit_rev(rx_next) : rx_next;
  assign tx_ready    = master_mode ? (st_reg == ST_IDLE) & fifo_rdy & ~mode_fault
                                   : slave_mode & (edge_reg == 4'h0);
  assign accept      = tx_valid & tx_ready;

  // master select bit: software write, dropped on a select fault
  always_ff @(posedge clk)
    if (sys_rst)
      master_reg <= 1'b0;
    else if (mode_fault)
      master_reg <= 1'b0;
    else if (master_write)
      master_reg <= master_wdata;

  // master clock generator; no byte starts while the receive fifo is full, a running byte is not stalled
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      st_reg  <= ST_IDLE;
      div_reg <= '0;
    end
    else
    begin
      unique case (st_reg)
        ST_IDLE:
        begin
          div_reg <= '0;
          if (accept & master_mode)
            st_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          div_reg <= m_tick ? '0 : div_reg + 1'b1;
          if (m_end | mode_fault | ~master_mode)
            st_reg <= ST_IDLE;
        end
      endcase
    end

  // edge counter and shift registers
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      edge_reg  <= 4'h0;
      rx_sr_reg <= BYTE_RST;
      tx_sr_reg <= BYTE_RST;
    end
    else
    begin
      if ((slave_mode & ss_s) | mode_fault | ~spi_enable)
      begin
        edge_reg  <= 4'h0;
        rx_sr_reg <= BYTE_RST;
      end
      else if (ev)
      begin
        edge_reg <= edge_reg + 1'b1;
        if (sample)
          rx_sr_reg <= rx_next;
        else if (~(clock_sample_phase & (edge_reg == 4'h0)))
          tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
      end
      if (accept)
        tx_sr_reg <= bit_order_select ? bit_rev(tx_data) : tx_data;
    end

  // serial clock level, idle at the polarity setting
  always_ff @(posedge clk)
    if (sys_rst)
      sck_reg <= 1'b0;
    else if (st_reg == ST_RUN && ev)
      sck_reg <= ~sck_reg;
    else if (st_reg == ST_IDLE)
      sck_reg <= clock_idle_polarity;

  // receive buffer holds the newest byte; the fifo keeps older ones
  always_ff @(posedge clk)
    if (sys_rst)
      rx_buf_reg <= BYTE_RST;
    else if (done)
      rx_buf_reg <= rx_byte;

  assign flag_next = (slave_mode & done) | m_end | mode_fault | (flag_reg & ~flag_clear);

  // flags: a set in the clearing cycle wins; nothing here depends on cpu sleep
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      flag_reg <= 1'b0;
      ovr_reg  <= 1'b0;
      irq_reg  <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      ovr_reg  <= (done & ~fifo_rdy) | (ovr_reg & ~flag_clear);
      irq_reg  <= flag_next & transfer_irq_enable;
    end

  smsc_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (done),
    .in_ready  (fifo_rdy),
    .in_data   (rx_byte),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign master_select_bit  = master_reg;
  assign transfer_done_flag = flag_reg;
  assign rx_overrun_flag    = ovr_reg;
  assign transfer_irq       = irq_reg;
  assign rx_buf             = rx_buf_reg;
  assign sck_out            = sck_reg;
  assign mosi_out           = tx_sr_reg[7];
  assign miso_out           = tx_sr_reg[7];
  assign sck_oe_n           = ~(master_mode & user_sck_dir);
  assign mosi_oe_n          = ~(master_mode & user_mosi_dir);
  assign miso_oe_n          = ~(slave_sel & user_miso_dir);

  a_master_start: assert property (@(posedge clk) disable iff (sys_rst)
    accept & master_mode |=> st_reg == ST_RUN)
    else $error("master write did not start clock");
  a_master_end: assert property (@(posedge clk) disable iff (sys_rst)
    m_end |=> flag_reg && st_reg == ST_IDLE)
    else $error("master byte end without flag or stop");
  a_irq_follow: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(flag_reg) && transfer_irq_enable |-> transfer_irq)
    else $error("interrupt missing after done flag");
  a_rx_buffer: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> rx_buf_reg == $past(rx_byte))
    else $error("receive buffer not updated");
  a_slave_idle: assert property (@(posedge clk) disable iff (sys_rst)
    slave_mode & ss_s |-> miso_oe_n ##1 (edge_reg == 4'h0 || !slave_mode))
    else $error("slave active while deselected");
  a_slave_flag: assert property (@(posedge clk) disable iff (sys_rst)
    slave_mode & done |=> flag_reg)
    else $error("slave byte without done flag");
  a_fault_drop: assert property (@(posedge clk) disable iff (sys_rst)
    mode_fault |=> !master_reg && flag_reg && st_reg == ST_IDLE)
    else $error("select fault not handled");
  a_miso_input: assert property (@(posedge clk) disable iff (sys_rst)
    master_mode |-> miso_oe_n && (sck_oe_n == !user_sck_dir))
    else $error("master pin directions wrong");
  a_sck_idle: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg == ST_IDLE [*2] |-> sck_out == $past(clock_idle_polarity))
    else $error("serial clock not at idle level");
  a_slave_hold: assert property (@(posedge clk) disable iff (sys_rst)
    slave_mode & ss_s & ~accept |=> tx_sr_reg == $past(tx_sr_reg))
    else $error("slave data moved while deselected");
  a_slave_reset: assert property (@(posedge clk) disable iff (sys_rst)
    slave_mode & ss_s |=> rx_sr_reg == BYTE_RST)
    else $error("partial bits kept after deselect");
  a_tx_busy: assert property (@(posedge clk) disable iff (sys_rst)
    master_mode && st_reg == ST_RUN |-> !tx_ready)
    else $error("transmit byte taken during shift");
  a_rx_push: assert property (@(posedge clk) disable iff (sys_rst)
    done & fifo_rdy |=> rx_valid)
    else $error("finished byte not queued");
  a_irq_gated: assert property (@(posedge clk) disable iff (sys_rst)
    !transfer_irq_enable |=> !transfer_irq)
    else $error("interrupt raised while disabled");
  a_slave_pins: assert property (@(posedge clk) disable iff (sys_rst)
    slave_mode |-> sck_oe_n && mosi_oe_n)
    else $error("slave drives clock or data-out pin");
  a_sck_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg == ST_RUN && ev |=> sck_out != $past(sck_out))
    else $error("serial clock missed an edge");
endmodule // smsc_core

/* File: rtl/smsc_pkg.sv */
// shared constants of the serial master/slave core
// assumes a single system clock; no bus, control bits are plain ports
package smsc_pkg;
  localparam int BYTE_BITS  = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int HALF_W     = 7;
  // master divide ratios for the four rate codes, normal speed
  localparam logic [HALF_W:0] DIV_RATE0 = 8'h04;
  localparam logic [HALF_W:0] DIV_RATE1 = 8'h10;
  localparam logic [HALF_W:0] DIV_RATE2 = 8'h40;
  localparam logic [HALF_W:0] DIV_RATE3 = 8'h80;
  localparam logic [3:0]      LAST_EDGE = 4'hf;
  localparam logic [2:0]      LAST_BIT  = 3'h7;
  localparam logic [7:0]      BYTE_RST  = 8'h00;

  typedef enum logic [0:0] {ST_IDLE = 1'h0, ST_RUN = 1'h1} smsc_state_t;

  // half serial-clock period in system clocks; double rate halves it
  function automatic logic [HALF_W-1:0] rate_half(input logic dbl, input logic [1:0] sel);
    logic [HALF_W:0] d;
    d = DIV_RATE0;
    unique case (sel)
      2'h0: d = DIV_RATE0;
      2'h1: d = DIV_RATE1;
      2'h2: d = DIV_RATE2;
      2'h3: d = DIV_RATE3;
    endcase
    rate_half = dbl ? {1'b0, d[HALF_W:2]} : d[HALF_W:1];
  endfunction

  function automatic logic [7:0] bit_rev(input logic [7:0] x);
    bit_rev = {<<{x}};
  endfunction
endpackage

/* File: rtl/smsc_fifo.sv */
// receive byte fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
module smsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_reg];

  always_ff @(posedge clk)
    if (push)
      mem[wr_reg] <= in_data;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule // smsc_fifo

/* File: tb/smsc_peer.sv */
// behavioural peer slave on the far side of the port: mode 0, msb first
// assumes select comes from the bench and clock and data from the master
module smsc_peer (
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [7:0] rsh = 8'h00;
  logic       last = 1'b0;
  initial rx = 8'h00;
  always @(negedge ss_n) sh = tx;
  always @(posedge sck) if (!ss_n) rsh = {rsh[6:0], mosi};
  always @(negedge sck) if (!ss_n) sh = {sh[6:0], 1'b0};
  always @(posedge ss_n) rx = rsh;
  always @(posedge ss_n) last = sh[7];
  // released line shows the inverse of its last level
  assign miso = ss_n ? ~last : sh[7];
endmodule // smsc_peer

/* File: tb/testbench.sv */
// self-checking bench: master transfers at every rate, slave receive, select fault
// assumes the peer model on the master pins and the bench as external master
module testbench
  import smsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIVS [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic clk, sys_rst, spi_enable, master_write, master_wdata, bit_order_select;
  logic clock_idle_polarity, clock_sample_phase, rate_select_high, rate_select_low;
  logic double_rate_bit, transfer_irq_enable, ss_dir_out, user_mosi_dir, user_sck_dir;
  logic user_miso_dir, tx_valid, tx_ready, flag_clear, transfer_done_flag;
  logic rx_overrun_flag, transfer_irq, rx_valid, rx_ready, sck_out, sck_oe_n;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, master_select_bit;
  logic s_sck, s_mosi, s_ss, p_ss, p_miso, m;
  logic [7:0] tx_data, rx_buf, rx_data, ptx, p_rx, mv;
  int miscompares = 0;
  int n_compared = 0;
  int cnt = 0;
  int n;
  smsc_core i_smsc_core (.clk, .sys_rst, .spi_enable, .master_write, .master_wdata,
    .master_select_bit, .bit_order_select, .clock_idle_polarity, .clock_sample_phase,
    .rate_select_high, .rate_select_low, .double_rate_bit, .transfer_irq_enable,
    .ss_dir_out, .user_mosi_dir, .user_sck_dir, .user_miso_dir, .tx_valid, .tx_ready,
    .tx_data, .flag_clear, .transfer_done_flag, .rx_overrun_flag, .transfer_irq, .rx_buf,
    .rx_valid, .rx_ready, .rx_data, .sck_in(s_sck), .sck_out, .sck_oe_n, .mosi_in(s_mosi),
    .mosi_out, .mosi_oe_n, .miso_in(p_miso), .miso_out, .miso_oe_n, .ss_n_in(s_ss));
  smsc_peer i_smsc_peer (.ss_n(p_ss), .sck(sck_out), .mosi(mosi_out), .tx(ptx),
    .miso(p_miso), .rx(p_rx));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cnt++;
    if (cnt == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic load(input logic [7:0] d);
    while (tx_ready !== 1'b1) @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    cyc(1);
    tx_valid = 1'b0;
  endtask
  task automatic set_mode(input logic v);
    master_wdata = v;
    master_write = 1'b1;
    cyc(1);
    master_write = 1'b0;
  endtask
  task automatic clr();
    flag_clear = 1'b1;
    cyc(1);
    flag_clear = 1'b0;
  endtask
  // one bit as external master, clock period of 20 system clocks
  task automatic sbit(input logic b, output logic q);
    s_mosi = b;
    cyc(10);
    s_sck = 1'b1;
    q = miso_out;
    cyc(10);
    s_sck = 1'b0;
  endtask
  initial
  begin
    {sys_rst, spi_enable, master_write, master_wdata, bit_order_select} = 5'h10;
    {clock_idle_polarity, clock_sample_phase, rate_select_high, rate_select_low} = 4'h0;
    {double_rate_bit, transfer_irq_enable, ss_dir_out, tx_valid, flag_clear} = 5'h04;
    {user_mosi_dir, user_sck_dir, user_miso_dir, rx_ready} = 4'he;
    {s_sck, s_mosi, s_ss, p_ss, tx_data, ptx} = {4'h3, 16'h0000};
    cyc(3);
    sys_rst = 1'b0;
    spi_enable = 1'b1;
    set_mode(1'b1);
    chk("miso_oe_n master", miso_oe_n, 1);
    chk("sck_oe_n master", sck_oe_n, 0);
    for (int i = 0; i < 8; i++)
    begin
      {double_rate_bit, rate_select_high, rate_select_low} = 3'(i);
      transfer_irq_enable = i[0];
      ptx = 8'h3c ^ 8'(i);
      clr();
      p_ss = 1'b0;
      cyc(1);
      load(8'ha0 + 8'(i));
      n = 0;
      while (transfer_done_flag !== 1'b1)
      begin
        cyc(1);
        n++;
        if (n == 2) chk("tx_ready busy", tx_ready, 0);
      end
      chk("cycles", 16'(n), 16'(8 * DIVS[i]));
      chk("irq", transfer_irq, i[0]);
      cyc(3);
      chk("sck stopped", sck_out, 0);
      p_ss = 1'b1;
      cyc(1);
      chk("peer rx", p_rx, 8'ha0 + 8'(i));
      if (DIVS[i] >= 8) chk("rx_buf", rx_buf, ptx);
    end
    chk("fifo full", tx_ready, 0);
    for (int i = 0; i < 8; i++)
    begin
      chk("rx_valid", rx_valid, 1);
      if (DIVS[i] >= 8) chk("rx_data", rx_data, 8'h3c ^ 8'(i));
      rx_ready = 1'b1;
      cyc(1);
    end
    rx_ready = 1'b0;
    chk("fifo empty", rx_valid, 0);
    chk("no overrun", rx_overrun_flag, 0);
    {bit_order_select, clock_idle_polarity, clock_sample_phase} = 3'h7;
    {double_rate_bit, rate_select_high, rate_select_low} = 3'h5;
    clr();
    cyc(1);
    chk("sck idle high", sck_out, 1);
    p_ss = 1'b0;
    cyc(1);
    load(8'h01);
    n = 0;
    while (transfer_done_flag !== 1'b1)
    begin
      cyc(1);
      n++;
    end
    chk("cycles lsb", 16'(n), 16'(64));
    chk("sck idle after", sck_out, 1);
    p_ss = 1'b1;
    cyc(1);
    chk("peer lsb first", p_rx, 8'h80);
    {bit_order_select, clock_idle_polarity, clock_sample_phase} = 3'h0;
    $display("test master done");
    set_mode(1'b0);
    clr();
    s_ss = 1'b0;
    for (int k = 0; k < 3; k++) sbit(1'b1, m);
    s_ss = 1'b1;
    cyc(4);
    chk("partial flag", transfer_done_flag, 0);
    chk("miso idle", miso_oe_n, 1);
    load(8'h96);
    cyc(20);
    chk("miso held", miso_oe_n, 1);
    s_ss = 1'b0;
    cyc(4);
    chk("miso driven", miso_oe_n, 0);
    for (int k = 0; k < 8; k++)
    begin
      sbit(8'h5a >> (7 - k), m);
      mv = {mv[6:0], m};
    end
    cyc(6);
    chk("slave flag", transfer_done_flag, 1);
    chk("slave rx_buf", rx_buf, 8'h5a);
    chk("slave out", mv, 8'h96);
    chk("sck_oe_n slave", sck_oe_n, 1);
    chk("mosi_oe_n slave", mosi_oe_n, 1);
    user_miso_dir = 1'b0;
    cyc(1);
    chk("miso user", miso_oe_n, 1);
    s_ss = 1'b1;
    cyc(4);
    $display("test slave done");
    ss_dir_out = 1'b0;
    set_mode(1'b1);
    clr();
    cyc(2);
    chk("master set", master_select_bit, 1);
    s_ss = 1'b0;
    cyc(5);
    chk("fault master bit", master_select_bit, 0);
    chk("fault flag", transfer_done_flag, 1);
    chk("fault irq", transfer_irq, 1);
    chk("fault sck_oe_n", sck_oe_n, 1);
    $display("test fault done");
    complete_run();
  end
endmodule // testbench
